/* File: verilog/ufmc_top.sv */
// UART frame format, loop routing, transmitter enable and interrupt control with Wishbone slave
//
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "ufmc_defines.svh"

// Contract
// - Loop select routes transmitter output to receiver and leaves receive pin unused.
// - Wait-freeze bit set stops serial logic while the CPU waits.
// - Receiver source select is ignored while loop select is clear.
// - In loop, source 0 is internal loop-back, source 1 is single wire.
// - Start, eight data bits LSB first, optional ninth bit, then stop.
// - Wakeup method bit picks idle-line or address-mark wakeup for standby.
// - Idle needs 10 or 11 high bit times, start point set by type.
// - Parity enable generates and checks parity in the most significant data bit.
// - Parity type 0 is even, 1 is odd, over whole character.
// - Transmit empty enable requests interrupt while buffer-empty flag is set.
// - Transmit complete enable requests interrupt while complete flag is set.
// - Receive enable requests interrupt while receive-full flag is set.
// - Idle enable requests interrupt while idle flag is set.
// - Transmitter works only with enable set and then drives the transmit pin.
// - In single wire the direction bit decides whether the pin is driven.
// - Enable written off then on during activity queues one idle character.
// - After enable clears, the pin stays driven until pending traffic ends.
// - Second control register may be read or written at any time.
// - Receive pin is released when receiver is off or loop is set.
module ufmc_top (
    input  wire logic        sys_clk_in,
    input  wire logic        srst_in,
    input  wire logic        ce_in,
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [4:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic             wb_ack_out,
    output logic [31:0]      wb_dat_out,
    input  wire logic        bit_tick_in,
    input  wire logic        cpu_wait_in,
    input  wire logic        rxd_pin_in,
    input  wire logic        txd_pin_in,
    output logic             txd_out,
    output logic             txd_oe_n_out,
    output logic             rxd_claim_out,
    output logic             wake_method_out,
    output logic             irq_out
);
    logic [1:0]               rxd_sync_q;
    logic [1:0]               txd_sync_q;
    ufmc_pkg::ufmc_c1_t       c1_q;
    ufmc_pkg::ufmc_c2_t       c2_q;
    logic                     dir_q;
    logic [8:0]               tx_data_q;
    logic [8:0]               rx_data_q;
    logic                     tx_buffer_empty_flag_q;
    logic                     rx_buffer_full_flag_q;
    logic                     idle_q;
    logic                     pf_q;
    logic                     idle_pend_q;
    logic                     idle_arm_q;
    logic [11:0]              tx_sh_q;
    logic [3:0]               tx_cnt_q;
    ufmc_pkg::ufmc_rx_st_t    rx_st_q;
    logic [3:0]               rx_cnt_q;
    logic [10:0]              rx_sh_q;
    logic [3:0]               idle_cnt_q;

    logic                     bus_go;
    logic                     wr_go;
    logic                     rd_go;
    logic [2:0]               idx;
    logic                     data_wr;
    logic                     data_rd;
    logic                     run;
    logic                     step;
    logic                     single;
    logic [3:0]               flen;
    logic [3:0]               ilim;
    logic                     tx_busy;
    logic                     tc;
    logic                     rx_in;
    logic [8:0]               d9;
    logic [11:0]              tx_frame;
    logic                     load_idle;
    logic                     load_data;
    logic [10:0]              rx_full;
    logic [8:0]               rx_word;
    logic                     rx_bad;
    logic                     rx_done;
    logic                     count_ok;
    logic                     idle_hit;
    logic                     own;
    logic [8:0]               rd_val;

    // Bus decode: one request per ack, register lane 0 only
    assign bus_go  = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    assign wr_go   = bus_go & wb_we_in & wb_sel_in[0];
    assign rd_go   = bus_go & ~wb_we_in;
    assign idx     = wb_adr_in[4:2];
    assign data_wr = wr_go & (idx == `UFMC_IDX_DATA);
    assign data_rd = rd_go & (idx == `UFMC_IDX_DATA);

    // Serial logic runs unless frozen during CPU wait
    assign run    = ce_in & ~(cpu_wait_in & c1_q.freeze);
    assign step   = run & bit_tick_in;
    assign single = c1_q.loop & c1_q.receiver_source_select;
    assign flen   = c1_q.nine ? `UFMC_FRAME_LEN9 : `UFMC_FRAME_LEN8;
    assign ilim   = c1_q.nine ? `UFMC_IDLE_BITS9 : `UFMC_IDLE_BITS8;
    assign tx_busy = (tx_cnt_q != 4'h0);
    assign tc      = tx_buffer_empty_flag_q & ~tx_busy & ~idle_pend_q;

    // Receiver input: pin, internal loop, or shared transmit pin node
    assign rx_in = ~c1_q.loop ? rxd_sync_q[1] :
                   (c1_q.receiver_source_select ? txd_sync_q[1] : txd_out);

    // Transmit character with parity in the top data bit
    always_comb
    begin
        d9 = tx_data_q;
        if (c1_q.pe && c1_q.nine)
        begin
            d9[8] = (^tx_data_q[7:0]) ^ c1_q.odd;
        end
        else if (c1_q.pe)
        begin
            d9[7] = (^tx_data_q[6:0]) ^ c1_q.odd;
        end
    end
    assign tx_frame = c1_q.nine ? {3'h7, d9} : {4'hf, d9[7:0]};

    // Queued idle goes before buffered data; data starts only while enabled or back to back behind a busy frame
    assign load_idle = step & ~tx_busy & idle_pend_q;
    assign load_data = step & (~tx_busy | (tx_cnt_q == 4'h1)) & ~load_idle & ~idle_pend_q
                       & ~tx_buffer_empty_flag_q & ~data_wr & (c2_q.te | tx_busy);

    // Received character and parity check
    assign rx_full  = {rx_in, rx_sh_q[10:1]};
    assign rx_word  = c1_q.nine ? rx_full[9:1] : {1'h0, rx_full[9:2]};
    assign rx_bad   = c1_q.pe & ((^rx_word) ^ c1_q.odd);
    assign rx_done  = step & c2_q.re & (rx_st_q == ufmc_pkg::RX_DATA) & (rx_cnt_q == 4'h1);
    assign count_ok = rx_in & ~(c1_q.idle_count_type & (rx_st_q == ufmc_pkg::RX_DATA));
    assign idle_hit = step & c2_q.re & count_ok & idle_arm_q
                      & (idle_cnt_q == 4'(ilim - 4'h1));

    // Pin ownership lasts while traffic is pending
    assign own = c2_q.te | tx_busy | idle_pend_q;

    // Read mux
    always_comb
    begin
        unique case (idx)
            `UFMC_IDX_C1:   rd_val = {1'h0, c1_q};
            `UFMC_IDX_C2:   rd_val = {1'h0, c2_q};
            `UFMC_IDX_STAT: rd_val = {1'h0, tx_buffer_empty_flag_q, tc, rx_buffer_full_flag_q, idle_q, 3'h0, pf_q};
            `UFMC_IDX_DATA: rd_val = rx_data_q;
            `UFMC_IDX_AUX:  rd_val = {8'h00, dir_q};
            default:        rd_val = 9'h000;
        endcase
    end

    // Two-stage synchronisers for the pins
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            rxd_sync_q <= 2'h3;
            txd_sync_q <= 2'h3;
        end
        else if (ce_in)
        begin
            rxd_sync_q <= {rxd_sync_q[0], rxd_pin_in};
            txd_sync_q <= {txd_sync_q[0], txd_pin_in};
        end
    end

    // Wishbone answer one cycle after the request
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            wb_ack_out <= 1'h0;
            wb_dat_out <= 32'h0000_0000;
        end
        else if (ce_in)
        begin
            wb_ack_out <= bus_go;
            if (rd_go)
            begin
                wb_dat_out <= {23'h00_0000, rd_val};
            end
        end
    end

    // Control registers, writable at any time
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            c1_q      <= ufmc_pkg::ufmc_c1_t'(`UFMC_C1_RST);
            c2_q      <= ufmc_pkg::ufmc_c2_t'(`UFMC_C2_RST);
            dir_q     <= `UFMC_AUX_RST;
            tx_data_q <= 9'h000;
        end
        else if (ce_in && wr_go)
        begin
            unique case (idx)
                `UFMC_IDX_C1:   c1_q <= ufmc_pkg::ufmc_c1_t'(wb_dat_in[7:0]);
                `UFMC_IDX_C2:   c2_q <= ufmc_pkg::ufmc_c2_t'(wb_dat_in[7:0]);
                `UFMC_IDX_DATA: tx_data_q <= wb_dat_in[8:0];
                `UFMC_IDX_AUX:  dir_q <= wb_dat_in[`UFMC_AUX_DIR];
                default:        ;
            endcase
        end
    end

    // Status flags; a hardware set wins over a software clear
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            tx_buffer_empty_flag_q      <= 1'h1;
            rx_buffer_full_flag_q      <= 1'h0;
            idle_q      <= 1'h0;
            pf_q        <= 1'h0;
            idle_pend_q <= 1'h0;
        end
        else if (ce_in)
        begin
            if (load_data)
                tx_buffer_empty_flag_q <= 1'h1;
            else if (data_wr)
                tx_buffer_empty_flag_q <= 1'h0;
            if (rx_done)
                rx_buffer_full_flag_q <= 1'h1;
            else if (data_rd)
                rx_buffer_full_flag_q <= 1'h0;
            if (idle_hit)
                idle_q <= 1'h1;
            else if (wr_go && idx == `UFMC_IDX_STAT && wb_dat_in[`UFMC_ST_IDLE])
                idle_q <= 1'h0;
            if (rx_done && rx_bad)
                pf_q <= 1'h1;
            else if (wr_go && idx == `UFMC_IDX_STAT && wb_dat_in[`UFMC_ST_PF])
                pf_q <= 1'h0;
            if (wr_go && idx == `UFMC_IDX_C2 && wb_dat_in[`UFMC_C2_TE] && !c2_q.te)
                idle_pend_q <= 1'h1;
            else if (load_idle)
                idle_pend_q <= 1'h0;
        end
    end

    // Transmit shifter: start bit on data load, then one bit per tick
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            tx_sh_q  <= 12'hfff;
            tx_cnt_q <= 4'h0;
            txd_out  <= 1'h1;
        end
        else if (load_data)
        begin
            txd_out  <= 1'h0;
            tx_sh_q  <= tx_frame;
            tx_cnt_q <= flen;
        end
        else if (load_idle)
        begin
            txd_out  <= 1'h1;
            tx_sh_q  <= 12'hfff;
            tx_cnt_q <= flen;
        end
        else if (step && tx_busy)
        begin
            txd_out  <= (tx_cnt_q == 4'h1) ? 1'h1 : tx_sh_q[0];
            tx_sh_q  <= {1'h1, tx_sh_q[11:1]};
            tx_cnt_q <= tx_cnt_q - 4'h1;
        end
    end

    // Receiver: hunt for start, then collect data and stop bits
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            rx_st_q   <= ufmc_pkg::RX_HUNT;
            rx_cnt_q  <= 4'h0;
            rx_sh_q   <= 11'h000;
            rx_data_q <= 9'h000;
        end
        else if (step && !c2_q.re)
        begin
            rx_st_q <= ufmc_pkg::RX_HUNT;
        end
        else if (step)
        begin
            unique case (rx_st_q)
                ufmc_pkg::RX_HUNT:
                begin
                    if (!rx_in)
                    begin
                        rx_st_q  <= ufmc_pkg::RX_DATA;
                        rx_cnt_q <= 4'(flen - 4'h1);
                    end
                end
                ufmc_pkg::RX_DATA:
                begin
                    rx_sh_q  <= rx_full;
                    rx_cnt_q <= rx_cnt_q - 4'h1;
                    if (rx_cnt_q == 4'h1)
                    begin
                        rx_st_q   <= ufmc_pkg::RX_HUNT;
                        rx_data_q <= rx_word;
                    end
                end
            endcase
        end
    end

    // Idle line counter, armed by each start bit
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            idle_cnt_q <= 4'h0;
            idle_arm_q <= 1'h0;
        end
        else if (step && c2_q.re)
        begin
            if (!count_ok)
                idle_cnt_q <= 4'h0;
            else if (idle_cnt_q != 4'hf)
                idle_cnt_q <= idle_cnt_q + 4'h1;
            if (rx_st_q == ufmc_pkg::RX_HUNT && !rx_in)
                idle_arm_q <= 1'h1;
            else if (idle_hit)
                idle_arm_q <= 1'h0;
        end
    end

    // Pin control, wakeup method and interrupt request
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            txd_oe_n_out    <= 1'h1;
            rxd_claim_out   <= 1'h0;
            wake_method_out <= 1'h0;
            irq_out         <= 1'h0;
        end
        else if (ce_in)
        begin
            txd_oe_n_out    <= ~(own & ~(single & ~dir_q));
            rxd_claim_out   <= c2_q.re & ~c1_q.loop;
            wake_method_out <= c1_q.wake;
            irq_out         <= (c2_q.tx_empty_irq_enable & tx_buffer_empty_flag_q) | (c2_q.tx_complete_irq_enable & tc)
                               | (c2_q.rx_full_irq_enable & rx_buffer_full_flag_q) | (c2_q.idle_irq_enable & idle_q);
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);

    sequence s_te_rearm;
        ce_in && wr_go && idx == `UFMC_IDX_C2 && wb_dat_in[`UFMC_C2_TE] && !c2_q.te;
    endsequence
    sequence s_rx_stop;
        ce_in && rx_done;
    endsequence

    a_queued_idle:  assert property (s_te_rearm |=> idle_pend_q)
        else $error("Enable rearm did not queue idle");
    a_rx_word:      assert property (s_rx_stop |=> rx_buffer_full_flag_q && rx_data_q == $past(rx_word))
        else $error("Received word not stored");
    a_rx_parity:    assert property (s_rx_stop ##0 rx_bad |=> pf_q)
        else $error("Parity error not flagged");
    a_parity_good:  assert property (s_rx_stop ##0 (c1_q.pe && (^rx_word) == c1_q.odd)
                                     ##0 !pf_q ##0 !wr_go |=> !pf_q)
        else $error("Good parity flagged");
    a_tx_parity:    assert property (load_data && c1_q.pe && !c1_q.nine
                                     |=> (^tx_sh_q[7:0]) == $past(c1_q.odd))
        else $error("Generated parity wrong");
    a_tx_start:     assert property (load_data |=> !txd_out && tx_cnt_q == $past(flen))
        else $error("Start bit or length wrong");
    a_wait_freeze:  assert property (ce_in && cpu_wait_in && c1_q.freeze
                                     |=> $stable(tx_cnt_q) && $stable(rx_st_q))
        else $error("Serial logic ran while frozen");
    a_rx_src_pin:   assert property (step && c2_q.re && !c1_q.loop && !rxd_sync_q[1]
                                     && rx_st_q == ufmc_pkg::RX_HUNT
                                     |=> rx_st_q == ufmc_pkg::RX_DATA)
        else $error("Pin start bit missed");
    a_rx_loopback:  assert property (step && c2_q.re && c1_q.loop && !c1_q.receiver_source_select && !txd_out
                                     && rx_st_q == ufmc_pkg::RX_HUNT
                                     |=> rx_st_q == ufmc_pkg::RX_DATA)
        else $error("Loop start bit missed");
    a_rx_release:   assert property (ce_in && c1_q.loop |=> !rxd_claim_out)
        else $error("Receive pin held in loop");
    a_rx_off:       assert property (ce_in && !c2_q.re |=> !rxd_claim_out)
        else $error("Receive pin held while off");
    a_single_dir:   assert property (ce_in && single && !dir_q |=> txd_oe_n_out)
        else $error("Shared pin driven while receiving");
    a_pin_busy:     assert property (ce_in && tx_busy && !single |=> !txd_oe_n_out)
        else $error("Pin released during traffic");
    a_pin_te:       assert property (ce_in && c2_q.te && !single |=> !txd_oe_n_out)
        else $error("Pin not driven while enabled");
    a_wake_sel:     assert property (ce_in ##1 ce_in |=> wake_method_out == $past(c1_q.wake))
        else $error("Wake method not passed on");
    a_idle_set:     assert property (ce_in && idle_hit |=> idle_q ##1 (idle_q || $past(wr_go)))
        else $error("Idle not flagged");
    a_irq_tx:       assert property (ce_in && c2_q.tx_empty_irq_enable && tx_buffer_empty_flag_q |=> irq_out)
        else $error("Empty interrupt missing");
    a_irq_tc:       assert property (ce_in && c2_q.tx_complete_irq_enable && tc |=> irq_out)
        else $error("Complete interrupt missing");
    a_irq_rx:       assert property (ce_in && c2_q.rx_full_irq_enable && rx_buffer_full_flag_q |=> irq_out)
        else $error("Receive interrupt missing");
    a_irq_idle:     assert property (ce_in && c2_q.idle_irq_enable && idle_q |=> irq_out)
        else $error("Idle interrupt missing");
    a_irq_clear:    assert property (ce_in && !(c2_q.tx_empty_irq_enable && tx_buffer_empty_flag_q) && !(c2_q.tx_complete_irq_enable && tc)
                                     && !(c2_q.rx_full_irq_enable && rx_buffer_full_flag_q) && !(c2_q.idle_irq_enable && idle_q)
                                     |=> !irq_out)
        else $error("Interrupt without source");
endmodule : ufmc_top

/* File: common/ufmc_defines.svh */
// Register indices, field positions, reset values and serial counts for the frame control block
`ifndef UFMC_DEFINES_SVH
`define UFMC_DEFINES_SVH
`define UFMC_IDX_C1     3'h0
`define UFMC_IDX_C2     3'h1
`define UFMC_IDX_STAT   3'h2
`define UFMC_IDX_DATA   3'h3
`define UFMC_IDX_AUX    3'h4
`define UFMC_C1_RST     8'h00
`define UFMC_C2_RST     8'h00
`define UFMC_AUX_RST    1'h0
`define UFMC_C2_TE      3
`define UFMC_ST_TX_BUFFER_EMPTY_FLAG    7
`define UFMC_ST_TC      6
`define UFMC_ST_RX_BUFFER_FULL_FLAG    5
`define UFMC_ST_IDLE    4
`define UFMC_ST_PF      0
`define UFMC_AUX_DIR    0
`define UFMC_FRAME_LEN8 4'ha
`define UFMC_FRAME_LEN9 4'hb
`define UFMC_IDLE_BITS8 4'ha
`define UFMC_IDLE_BITS9 4'hb
`endif

/* File: common/ufmc_pkg.sv */
// Types shared by the frame control block
package ufmc_pkg;
    typedef struct packed {
        logic loop;
        logic freeze;
        logic receiver_source_select;
        logic nine;
        logic wake;
        logic idle_count_type;
        logic pe;
        logic odd;
    } ufmc_c1_t;
    typedef struct packed {
        logic tx_empty_irq_enable;
        logic tx_complete_irq_enable;
        logic rx_full_irq_enable;
        logic idle_irq_enable;
        logic te;
        logic re;
        logic rwu;
        logic sbk;
    } ufmc_c2_t;
    typedef enum logic [0:0] {RX_HUNT, RX_DATA} ufmc_rx_st_t;
endpackage : ufmc_pkg

/* File: verif/ufmc_partner.sv */
// Remote serial transceiver model facing the frame control block
`timescale 1ns/1ps
module ufmc_partner (
    input  wire logic       clk_in,
    input  wire logic       tick_in,
    input  wire logic       line_in,
    input  wire logic       nine_in,
    input  wire logic       send_in,
    input  wire logic [8:0] send_dat_in,
    output logic            rxd_out,
    output logic            got_out,
    output logic [8:0]      got_dat_out
);
    logic [3:0]  rcnt_q = 4'h0;
    logic [10:0] rsh_q  = 11'h000;
    logic [3:0]  tcnt_q = 4'h0;
    logic [10:0] tsh_q  = 11'h7ff;
    initial rxd_out = 1'b1;
    initial got_out = 1'b0;
    initial got_dat_out = 9'h000;

    // Decoder: one sample per tick, start low, data LSB first, then stop
    always @(posedge clk_in)
    begin
        got_out <= 1'b0;
        if (tick_in && rcnt_q == 4'h0 && !line_in)
            rcnt_q <= nine_in ? 4'ha : 4'h9;
        else if (tick_in && rcnt_q != 4'h0)
        begin
            rsh_q  <= {line_in, rsh_q[10:1]};
            rcnt_q <= rcnt_q - 4'h1;
            got_out <= (rcnt_q == 4'h1);
            got_dat_out <= nine_in ? rsh_q[10:2] : {1'b0, rsh_q[10:3]};
        end
    end

    // Sender: start, data LSB first, stop; line idles high, held there by rxd_out
    always @(posedge clk_in)
    begin
        if (send_in && tcnt_q == 4'h0)
        begin
            tsh_q  <= nine_in ? {1'b1, send_dat_in, 1'b0} : {2'h3, send_dat_in[7:0], 1'b0};
            tcnt_q <= nine_in ? 4'hb : 4'ha;
        end
        else if (tick_in && tcnt_q != 4'h0)
        begin
            rxd_out <= tsh_q[0];
            tsh_q   <= {1'b1, tsh_q[10:1]};
            tcnt_q  <= tcnt_q - 4'h1;
        end
    end
endmodule : ufmc_partner

/* File: verif/tb_uart_frame_mode_control.sv */
// Self-checking bench for the frame control block
`timescale 1ns/1ps
`include "ufmc_defines.svh"
module tb_uart_frame_mode_control;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, tick = 1'b0, cpu_wait = 1'b0;
    logic        send = 1'b0, loop_mode = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0, rng = 32'h0000001c;
    logic [8:0]  send_dat = 9'h000;
    logic [7:0]  c1_now = 8'h00, tcnt = 8'h00;
    logic [7:0]  fmt [6] = '{8'h00, 8'h02, 8'h03, 8'h08, 8'h12, 8'h13};
    logic [31:0] rdq [$];
    logic [8:0]  txq [$];
    int          mismatches = 0, compares = 0;
    wire         ack, txd, oe_n, claim, wake, irq, rxd, got;
    wire [31:0]  rdat;
    wire [8:0]   got_dat;
    wire         node = oe_n ? 1'b1 : txd;

    always #20 clk = ~clk;

    // One tick every eight clocks
    always @(posedge clk)
    begin
        tcnt <= tcnt + 8'h01;
        tick <= (tcnt[2:0] == 3'h7);
    end

    ufmc_top ufmc_top_i (.sys_clk_in(clk), .srst_in(srst), .ce_in(1'b1), .wb_cyc_in(cyc),
        .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat),
        .wb_ack_out(ack), .wb_dat_out(rdat), .bit_tick_in(tick), .cpu_wait_in(cpu_wait),
        .rxd_pin_in(rxd), .txd_pin_in(node), .txd_out(txd), .txd_oe_n_out(oe_n),
        .rxd_claim_out(claim), .wake_method_out(wake), .irq_out(irq));
    ufmc_partner ufmc_partner_i (.clk_in(clk), .tick_in(tick), .line_in(node),
        .nine_in(c1_now[4]), .send_in(send), .send_dat_in(send_dat), .rxd_out(rxd),
        .got_out(got), .got_dat_out(got_dat));

    task give_verdict;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    task automatic cmp_word(input string what, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, e, g);
        end
    endtask : cmp_word

    task automatic cmp_pin(input string what, input logic e, input logic g);
        cmp_word(what, {31'h0, e}, {31'h0, g});
    endtask : cmp_pin

    task automatic stall(input string what);
        mismatches++;
        $display("FAIL %s expected done seen timeout", what);
        give_verdict;
    endtask : stall

    // Classic single cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [2:0] idx, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= {idx, 2'h0};
        sel <= 4'hf;
        dat <= d;
        do @(posedge clk); while (ack !== 1'b1 && ++k < 40);
        if (k >= 40)
            stall("ack");
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : wb

    task automatic rd(input logic [2:0] idx, input logic [31:0] e);
        rdq.push_back(e);
        wb(1'b0, idx, 32'h0);
    endtask : rd

    task automatic wait_tx;
        int k;
        for (k = 0; k < 3000 && txq.size() != 0; k++)
            @(posedge clk);
        if (k >= 3000)
            stall("frame");
    endtask : wait_tx

    task automatic wait_irq;
        int k;
        for (k = 0; k < 3000 && irq !== 1'b1; k++)
            @(posedge clk);
        if (k >= 3000)
            stall("irq");
    endtask : wait_irq

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction : xs

    function automatic logic [8:0] exp_char(input logic [7:0] c, input logic [8:0] d);
        logic [8:0] e;
        e = c[4] ? d : {1'b0, d[7:0]};
        if (c[1] && c[4])
            e[8] = ^d[7:0] ^ c[0];
        if (c[1] && !c[4])
            e[7] = ^d[6:0] ^ c[0];
        return e;
    endfunction : exp_char

    // Read results against the oldest note, taken at the edge that samples ack
    always @(posedge clk)
        if (ack === 1'b1 && we === 1'b0 && rdq.size() > 0)
            cmp_word("read", rdq.pop_front(), rdat);

    // Characters decoded on the transmit node against the oldest note
    always @(posedge clk)
        if (got === 1'b1 && !loop_mode)
            cmp_word("char", txq.size() ? {23'h0, txq.pop_front()} : 32'hffff,
                     {23'h0, got_dat});

    initial
    begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        rd(`UFMC_IDX_C1, 32'h0);
        rd(`UFMC_IDX_C2, 32'h0);
        rd(`UFMC_IDX_STAT, 32'hc0);
        wb(1'b1, 3'h5, 32'hff);
        rd(3'h5, 32'h0);
        repeat (4)
        begin
            rng = xs(rng);
            wb(1'b1, `UFMC_IDX_C2, {24'h0, rng[7:0]});
            rd(`UFMC_IDX_C2, {24'h0, rng[7:0]});
        end
        $display("test registers done");
        // Let the idle frame queued by the random enable write finish first
        repeat (100) @(posedge clk);
        for (int b = 0; b < 5; b++)
        begin
            wb(1'b1, `UFMC_IDX_C2, 32'h80 >> b);
            repeat (3) @(negedge clk);
            cmp_pin("irq", b < 2, irq);
        end
        $display("test interrupts done");
        @(posedge clk);
        cpu_wait <= 1'b1;
        foreach (fmt[i])
        begin
            rng = xs(rng);
            c1_now = fmt[i];
            wb(1'b1, `UFMC_IDX_C1, {24'h0, fmt[i]});
            wb(1'b1, `UFMC_IDX_C2, 32'h08);
            cmp_pin("wake", fmt[i][3], wake);
            txq.push_back(exp_char(fmt[i], rng[8:0]));
            wb(1'b1, `UFMC_IDX_DATA, {23'h0, rng[8:0]});
            wait_tx;
        end
        rng = xs(rng);
        txq.push_back(exp_char(8'h13, rng[8:0]));
        wb(1'b1, `UFMC_IDX_DATA, {23'h0, rng[8:0]});
        repeat (30) @(posedge clk);
        wb(1'b1, `UFMC_IDX_C2, 32'h0);
        cmp_pin("oe_n", 1'b0, oe_n);
        rd(`UFMC_IDX_C2, 32'h0);
        wait_tx;
        repeat (20) @(negedge clk);
        cmp_pin("oe_n", 1'b1, oe_n);
        $display("test formats done");
        c1_now = 8'h40;
        wb(1'b1, `UFMC_IDX_C1, 32'h40);
        txq.push_back(exp_char(8'h40, 9'h05a));
        wb(1'b1, `UFMC_IDX_DATA, 32'h05a);
        repeat (200) @(posedge clk);
        cmp_word("held", 32'h1, txq.size());
        wb(1'b1, `UFMC_IDX_C2, 32'h08);
        repeat (200) @(posedge clk);
        cmp_word("frozen", 32'h1, txq.size());
        cpu_wait <= 1'b0;
        wait_tx;
        $display("test freeze done");
        c1_now = 8'h20;
        wb(1'b1, `UFMC_IDX_C1, 32'h20);
        wb(1'b1, `UFMC_IDX_C2, 32'h24);
        repeat (2) @(posedge clk);
        cmp_pin("claim", 1'b1, claim);
        rng = xs(rng);
        send_dat <= {1'b0, rng[7:0]};
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
        wait_irq;
        rd(`UFMC_IDX_DATA, {24'h0, rng[7:0]});
        repeat (3) @(negedge clk);
        cmp_pin("irq", 1'b0, irq);
        $display("test receive done");
        loop_mode = 1'b1;
        wb(1'b1, `UFMC_IDX_C1, 32'h80);
        wb(1'b1, `UFMC_IDX_C2, 32'h2c);
        cmp_pin("claim", 1'b0, claim);
        send_dat <= {1'b0, ~rng[7:0]};
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
        wb(1'b1, `UFMC_IDX_DATA, {24'h0, rng[7:0]});
        wait_irq;
        rd(`UFMC_IDX_DATA, {24'h0, rng[7:0]});
        wb(1'b1, `UFMC_IDX_C1, 32'ha0);
        wb(1'b1, `UFMC_IDX_AUX, 32'h0);
        repeat (3) @(negedge clk);
        cmp_pin("oe_n", 1'b1, oe_n);
        wb(1'b1, `UFMC_IDX_AUX, 32'h1);
        repeat (3) @(negedge clk);
        cmp_pin("oe_n", 1'b0, oe_n);
        $display("test loop done");
        give_verdict;
    end
endmodule : tb_uart_frame_mode_control
